// ===== tb/extra_external_interrupts_tb.sv
// Self-checking bench for the extra interrupt controller: register, pins and vectors.
// Assumes the package, the design files and the pin model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module extra_external_interrupts_tb;
  logic                   mclk;
  logic                   rstn;
  logic                   ce;
  xirq_pkg::xirq_sfr_type sfr;
  logic [1:0]             pin_low;
  logic [1:0]             gpio;
  logic [1:0]             svc_ack;
  wire logic [3:0]        aux;
  logic [7:0]             rdata;
  logic                   hit;
  logic [1:0]             irq_req;
  logic [1:0]             irq_hp;
  logic                   vvalid;
  logic [7:0]             vaddr;
  logic [2:0]             poll;
  logic [8:0]             exp_q[$];
  logic [7:0]             w;
  logic [7:0]             ctl;
  int                     n_mismatch;
  int                     compares;
  int                     seed;

  // ==========================================================================
  // Design and far side
  xirq_ctrl u_dut (.mclk(mclk), .rstn(rstn), .ce(ce), .sfr(sfr), .aux_nibble_port(aux),
    .svc_ack(svc_ack), .sfr_rdata(rdata), .sfr_hit(hit), .irq_req(irq_req),
    .irq_high_priority(irq_hp), .vector_valid(vvalid), .vector_addr(vaddr), .poll_pos(poll));
  xirq_pin_model u_pins (.req_low(pin_low), .gpio(gpio), .aux_nibble_port(aux));

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] expd);
    compares++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  task automatic give_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic bwr(input logic [7:0] d);
    sfr.byte_wr = 1'b1;
    sfr.addr = 8'hc0;
    sfr.wdata = d;
    cyc(1);
    sfr.byte_wr = 1'b0;
    cyc(1);
  endtask : bwr

  task automatic bitwr(input logic [7:0] a, input logic v);
    sfr.bit_wr = 1'b1;
    sfr.bit_addr = a;
    sfr.bit_val = v;
    cyc(1);
    sfr.bit_wr = 1'b0;
    cyc(1);
  endtask : bitwr

  // Issues a byte read and leaves the expected hit and data for the monitor.
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    exp_q.push_back({h, d});
    sfr.byte_rd = 1'b1;
    sfr.addr = a;
    cyc(1);
    sfr.byte_rd = 1'b0;
    cyc(1);
  endtask : rd

  // Bounded wait for one request line; running out ends the run.
  task automatic wait_irq(input int i, input logic v);
    int k;
    k = 0;
    while (irq_req[i] !== v && k < 12) begin
      cyc(1);
      k++;
    end
    check("irq_req wait", 9'(irq_req[i]), 9'(v));
    if (irq_req[i] !== v) give_verdict();
  endtask : wait_irq

  // Monitor: each taken read is answered one cycle later by data and hit.
  always @(posedge mclk) begin
    if (sfr.byte_rd === 1'b1) begin
      #2;
      check("read data", {hit, rdata}, exp_q.pop_front());
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 94824;
    n_mismatch = 0;
    compares = 0;
    rstn = 1'b0;
    ce = 1'b1;
    sfr = '0;
    pin_low = 2'h0;
    gpio = 2'h0;
    svc_ack = 2'h0;
    cyc(20);
    check("reset irq_req", 9'(irq_req), 9'h000);
    rstn = 1'b1;
    cyc(6);
    // Reset value, unmapped address and single-bit access.
    rd(8'hc0, 8'h00, 1'b1);
    rd(8'hc1, 8'h00, 1'b0);
    bitwr(8'hc2, 1'b1);
    rd(8'hc0, 8'h04, 1'b1);
    w = 8'h04;
    for (int b = 0; b < 8; b++) begin
      if (b != 1 && b != 5) begin
        bitwr(8'hc0 + 8'(b), 1'b1);
        w[b] = 1'b1;
        rd(8'hc0, w, 1'b1);
      end
    end
    bitwr(8'hc6, 1'b0);
    w[6] = 1'b0;
    rd(8'hc0, w, 1'b1);
    // A frozen clock enable must drop a write.
    ce = 1'b0;
    bwr(8'h00);
    ce = 1'b1;
    rd(8'hc0, w, 1'b1);
    // A bit address outside the register page, then a byte write beside a bit write.
    bitwr(8'hb6, 1'b1);
    rd(8'hc0, w, 1'b1);
    sfr.bit_wr = 1'b1;
    sfr.bit_addr = 8'hc6;
    sfr.bit_val = 1'b1;
    sfr.byte_wr = 1'b1;
    sfr.addr = 8'hc0;
    sfr.wdata = 8'h00;
    cyc(1);
    sfr.bit_wr = 1'b0;
    sfr.byte_wr = 1'b0;
    cyc(1);
    rd(8'hc0, 8'h00, 1'b1);
    // Random control values; pending flags stay clear with idle pins.
    for (int k = 0; k < 4; k++) begin
      w = 8'($random(seed)) & 8'hdd;
      gpio = 2'($random(seed));
      bwr(w);
      rd(8'hc0, w, 1'b1);
    end
    bwr(8'h00);
    // Edge mode per input: request, vector, service and a disabled edge.
    for (int ch = 0; ch < 2; ch++) begin
      ctl = (ch == 1) ? 8'h50 : 8'h05;
      bwr(ctl);
      pin_low[ch] = 1'b1;
      cyc(2);
      pin_low[ch] = 1'b0;
      wait_irq(ch, 1'b1);
      cyc(1);
      check("vector", {vvalid, vaddr}, (ch == 1) ? 9'h13b : 9'h133);
      check("poll", 9'(poll), (ch == 1) ? 9'h007 : 9'h006);
      rd(8'hc0, ctl | ((ch == 1) ? 8'h20 : 8'h02), 1'b1);
      svc_ack[ch] = 1'b1;
      cyc(1);
      svc_ack[ch] = 1'b0;
      wait_irq(ch, 1'b0);
      rd(8'hc0, ctl, 1'b1);
      ctl = (ch == 1) ? 8'h10 : 8'h01;
      bwr(ctl);
      pin_low[ch] = 1'b1;
      cyc(2);
      pin_low[ch] = 1'b0;
      cyc(8);
      check("masked irq", 9'(irq_req), 9'h000);
      rd(8'hc0, ctl | ((ch == 1) ? 8'h20 : 8'h02), 1'b1);
      bitwr((ch == 1) ? 8'hc5 : 8'hc1, 1'b0);
      rd(8'hc0, ctl, 1'b1);
    end
    // Level mode per input: request follows the pin and is not latched.
    for (int ch = 0; ch < 2; ch++) begin
      ctl = (ch == 1) ? 8'h40 : 8'h04;
      bwr(ctl);
      pin_low[ch] = 1'b1;
      wait_irq(ch, 1'b1);
      cyc(4);
      check("level hold", 9'(irq_req), (ch == 1) ? 9'h002 : 9'h001);
      pin_low[ch] = 1'b0;
      wait_irq(ch, 1'b0);
      cyc(4);
      check("level release", 9'(irq_req), 9'h000);
    end
    // Priority arbitration with both inputs low in level mode.
    pin_low = 2'h3;
    bwr(8'h44);
    wait_irq(1, 1'b1);
    for (int k = 0; k < 4; k++) begin
      ctl = 8'h44 | ((k[0] == 1'b1) ? 8'h80 : 8'h00) | ((k[1] == 1'b1) ? 8'h08 : 8'h00);
      bwr(ctl);
      cyc(2);
      check("priority", 9'(irq_hp), {7'h00, ctl[7], ctl[3]});
      check("winner", 9'(vaddr), (k == 1) ? 9'h03b : 9'h033);
    end
    pin_low = 2'h0;
    cyc(8);
    give_verdict();
  end
endmodule : extra_external_interrupts_tb
`default_nettype wire

// ===== tb/xirq_pin_model.sv
// Model of the external devices that drive the auxiliary nibble port pins.
// Assumes the bench asks for a low level per input just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module xirq_pin_model (
  input  wire logic [1:0] req_low,
  input  wire logic [1:0] gpio,
  output logic      [3:0] aux_nibble_port
);
  // ==========================================================================
  // Pin drive
  // Pulled-up request lines idle high and go low only while a device asks.
  assign aux_nibble_port = {~req_low[1], ~req_low[0], gpio};
endmodule : xirq_pin_model
`default_nettype wire

// ===== verilog/xirq_ctrl.sv
// Extra external interrupt controller: control register, two inputs and the request to the core.
// Assumes the core drives sfr accesses and service acknowledges synchronously to mclk.
`timescale 1ns/100ps
`default_nettype none
module xirq_ctrl (
  input  wire logic               mclk,
  input  wire logic               rstn,
  input  wire logic               ce,
  input  wire xirq_pkg::xirq_sfr_type sfr,
  input  wire logic [3:0]         aux_nibble_port,
  input  wire logic [1:0]         svc_ack,
  output logic [7:0]              sfr_rdata,
  output logic                    sfr_hit,
  output logic [1:0]              irq_req,
  output logic [1:0]              irq_high_priority,
  output logic                    vector_valid,
  output logic [7:0]              vector_addr,
  output logic [2:0]              poll_pos
);

  logic       rst_s1_reg;
  logic       rst_s2_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] rdata_reg;
  logic       hit_reg;
  logic [1:0] req_reg;
  logic [1:0] hp_reg;
  logic       vvalid_reg;
  logic [7:0] vaddr_reg;
  logic [2:0] poll_reg;
  logic [1:0] pending;

  // ==========================================================================
  // Reset release through two flip-flops.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  wire rst_n = rst_s2_reg;

  // ==========================================================================
  // Address decode and the write image for byte and single-bit accesses.
  wire        byte_hit   = (sfr.addr == xirq_pkg::XIRQ_CTRL_ADDR);
  wire        bit_hit    = (sfr.bit_addr[7:3] == xirq_pkg::XIRQ_BIT_PAGE);
  wire        byte_wr_en = sfr.byte_wr & byte_hit;
  wire        bit_wr_en  = sfr.bit_wr & bit_hit;
  wire [2:0]  bit_idx    = sfr.bit_addr[2:0];
  wire [7:0]  cur_image;
  wire [7:0]  bit_mask   = 8'h01 << bit_idx;
  wire [7:0]  bit_image  = sfr.bit_val ? (cur_image | bit_mask) : (cur_image & ~bit_mask);
  wire [7:0]  wr_image   = byte_wr_en ? sfr.wdata : bit_image;
  wire        wr_en      = byte_wr_en | bit_wr_en;

  // Live image: stored control bits with the pending flags spliced in.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      localparam int BASE = gi * 4;
      xirq_pkg::xirq_chan_type chan;
      wire pin_in = aux_nibble_port[gi == 0 ? xirq_pkg::XIRQ_PIN_B : xirq_pkg::XIRQ_PIN_C];
      wire pend_wr = byte_wr_en | (bit_wr_en & (bit_idx == 3'(BASE + xirq_pkg::XIRQ_F_PENDING)));

      assign chan.high_priority = ctrl_reg[BASE + xirq_pkg::XIRQ_F_HIGH_PRIO];
      assign chan.enable        = ctrl_reg[BASE + xirq_pkg::XIRQ_F_ENABLE];
      assign chan.pending       = pending[gi];
      assign chan.edge_select   = ctrl_reg[BASE + xirq_pkg::XIRQ_F_EDGE_SEL];
      assign cur_image[BASE+3:BASE] = chan;

      // Detector for one input, same behaviour as the classic pins.
      xirq_detect u_detect (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .ce          (ce),
        .pin_async   (pin_in),
        .edge_select (chan.edge_select),
        .sw_wr       (pend_wr),
        .sw_val      (wr_image[BASE + xirq_pkg::XIRQ_F_PENDING]),
        .svc_ack     (svc_ack[gi]),
        .pending     (pending[gi])
      );
    end
  endgenerate

  // Control register; the pending positions live in the detectors and store as zero here.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= xirq_pkg::XIRQ_CTRL_RESET;
    end else if (ce && wr_en) begin
      ctrl_reg <= wr_image & 8'hdd;
    end
  end

  // ==========================================================================
  // Requests gated by enable, priorities and the vector choice.
  wire [1:0] req_next = pending & {ctrl_reg[4 + xirq_pkg::XIRQ_F_ENABLE],
                                   ctrl_reg[xirq_pkg::XIRQ_F_ENABLE]};
  wire [1:0] hp_next  = {ctrl_reg[4 + xirq_pkg::XIRQ_F_HIGH_PRIO],
                         ctrl_reg[xirq_pkg::XIRQ_F_HIGH_PRIO]};
  wire       hi_b     = req_next[0] & hp_next[0];
  wire       hi_c     = req_next[1] & hp_next[1];
  wire       pick_c   = hi_c ? ~hi_b : (req_next[1] & ~req_next[0]);
  wire [7:0] vec_next = pick_c ? xirq_pkg::XIRQ_VECTOR_C : xirq_pkg::XIRQ_VECTOR_B;
  wire [2:0] pos_next = pick_c ? xirq_pkg::XIRQ_POLL_C : xirq_pkg::XIRQ_POLL_B;

  // Output registers toward the core.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg    <= 2'h0;
      hp_reg     <= 2'h0;
      vvalid_reg <= 1'b0;
      vaddr_reg  <= 8'h00;
      poll_reg   <= 3'h0;
      rdata_reg  <= 8'h00;
      hit_reg    <= 1'b0;
    end else if (ce) begin
      req_reg    <= req_next;
      hp_reg     <= hp_next;
      vvalid_reg <= |req_next;
      vaddr_reg  <= vec_next;
      poll_reg   <= pos_next;
      rdata_reg  <= (sfr.byte_rd && byte_hit) ? cur_image : 8'h00;
      hit_reg    <= sfr.byte_rd & byte_hit;
    end
  end

  assign sfr_rdata         = rdata_reg;
  assign sfr_hit           = hit_reg;
  assign irq_req           = req_reg;
  assign irq_high_priority = hp_reg;
  assign vector_valid      = vvalid_reg;
  assign vector_addr       = vaddr_reg;
  assign poll_pos          = poll_reg;

  // ==========================================================================
  // Checks
  property p_bit_set_c2;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !sfr.byte_wr && sfr.bit_wr && sfr.bit_addr == 8'hc2 && sfr.bit_val) |=> ctrl_reg[2];
  endproperty
  a_bit_set_c2: assert property (p_bit_set_c2) else $error("Bit set at c2 missed enable.");

  property p_bit_only;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !sfr.byte_wr && bit_wr_en) |=> ((ctrl_reg ^ $past(ctrl_reg)) & ~$past(bit_mask)) == 8'h00;
  endproperty
  a_bit_only: assert property (p_bit_only) else $error("Bit access touched other bits.");

  property p_req_c_enable;
    @(posedge mclk) disable iff (!rst_n)
      ce ##1 irq_req[1] |-> $past(ctrl_reg[6]) && $past(pending[1]);
  endproperty
  a_req_c_enable: assert property (p_req_c_enable) else $error("Input C requested while disabled.");

  property p_req_b_enable;
    @(posedge mclk) disable iff (!rst_n)
      ce ##1 irq_req[0] |-> $past(ctrl_reg[2]) && $past(pending[0]);
  endproperty
  a_req_b_enable: assert property (p_req_b_enable) else $error("Input B requested while disabled.");

  property p_prio_c;
    @(posedge mclk) disable iff (!rst_n)
      ce |=> irq_high_priority[1] == $past(ctrl_reg[7]);
  endproperty
  a_prio_c: assert property (p_prio_c) else $error("Input C priority wrong.");

  property p_prio_b;
    @(posedge mclk) disable iff (!rst_n)
      ce |=> irq_high_priority[0] == $past(ctrl_reg[3]);
  endproperty
  a_prio_b: assert property (p_prio_b) else $error("Input B priority wrong.");

  property p_vec_b;
    @(posedge mclk) disable iff (!rst_n)
      (ce && req_next == 2'b01) |=> vector_addr == 8'h33 && poll_pos == 3'h6;
  endproperty
  a_vec_b: assert property (p_vec_b) else $error("Input B vector wrong.");

  property p_vec_c;
    @(posedge mclk) disable iff (!rst_n)
      (ce && req_next == 2'b10) |=> vector_addr == 8'h3b && poll_pos == 3'h7;
  endproperty
  a_vec_c: assert property (p_vec_c) else $error("Input C vector wrong.");

  property p_byte_wins;
    @(posedge mclk) disable iff (!rst_n)
      (ce && byte_wr_en && bit_wr_en) |=> ctrl_reg == ($past(sfr.wdata) & 8'hdd);
  endproperty
  a_byte_wins: assert property (p_byte_wins) else $error("Bit write beat a byte write.");

  property p_read_hit;
    @(posedge mclk) disable iff (!rst_n)
      ce |=> sfr_hit == ($past(sfr.byte_rd) && ($past(sfr.addr) == xirq_pkg::XIRQ_CTRL_ADDR));
  endproperty
  a_read_hit: assert property (p_read_hit) else $error("Read hit flag wrong.");

  property p_read_miss_zero;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !(sfr.byte_rd && byte_hit)) |=> sfr_rdata == 8'h00;
  endproperty
  a_read_miss_zero: assert property (p_read_miss_zero) else $error("Read data not zero on a miss.");

  property p_vvalid_any;
    @(posedge mclk) disable iff (!rst_n)
      ce |=> vector_valid == (irq_req != 2'h0);
  endproperty
  a_vvalid_any: assert property (p_vvalid_any) else $error("Vector valid disagrees with requests.");

  property p_same_level_b;
    @(posedge mclk) disable iff (!rst_n)
      (ce && req_next == 2'b11 && hp_next[0] == hp_next[1]) |=> vector_addr == xirq_pkg::XIRQ_VECTOR_B;
  endproperty
  a_same_level_b: assert property (p_same_level_b) else $error("Same level did not poll B first.");

  property p_high_c_wins;
    @(posedge mclk) disable iff (!rst_n)
      (ce && req_next == 2'b11 && hp_next == 2'b10) |=> vector_addr == xirq_pkg::XIRQ_VECTOR_C;
  endproperty
  a_high_c_wins: assert property (p_high_c_wins) else $error("High priority C lost to B.");

  c_both_req: cover property (@(posedge mclk) disable iff (!rst_n) irq_req == 2'b11);
  c_c_wins: cover property (@(posedge mclk) disable iff (!rst_n) irq_req == 2'b11 && vector_addr == 8'h3b);
  c_bit_write: cover property (@(posedge mclk) disable iff (!rst_n) bit_wr_en && ce);

endmodule : xirq_ctrl
`default_nettype wire

// ===== verilog/xirq_detect.sv
// One interrupt input: pin synchroniser, edge or level detection and the pending flag.
// Assumes the pin is asynchronous and idles high; service acknowledge comes from the core clock.
`timescale 1ns/100ps
`default_nettype none
module xirq_detect (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin_async,
  input  wire logic edge_select,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  input  wire logic svc_ack,
  output logic      pending
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic pending_reg;
  logic pending_next;
  wire  fall_seen;

  // Two-stage synchroniser, then a delayed copy for edge detection.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else if (ce) begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign fall_seen = prev_reg & ~sync2_reg;  // High sample followed by low sample.

  // Edge mode: a detected edge beats both the service clear and a software write.
  // Level mode: the flag mirrors the low pin and holds nothing once it rises.
  always_comb begin
    if (!edge_select) begin
      pending_next = ~sync2_reg;
    end else if (fall_seen) begin
      pending_next = 1'b1;
    end else if (svc_ack) begin
      pending_next = 1'b0;
    end else if (sw_wr) begin
      pending_next = sw_val;
    end else begin
      pending_next = pending_reg;
    end
  end

  // Pending flag register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 1'b0;
    end else if (ce) begin
      pending_reg <= pending_next;
    end
  end

  assign pending = pending_reg;

  // ==========================================================================
  // Checks
  property p_edge_sets;
    @(posedge mclk) disable iff (!rst_n)
      (ce && edge_select && fall_seen) |=> pending_reg;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("Edge did not set pending.");

  property p_ack_clears;
    @(posedge mclk) disable iff (!rst_n)
      (ce && edge_select && !fall_seen && svc_ack) |=> !pending_reg;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("Service did not clear pending.");

  property p_level_follows;
    @(posedge mclk) disable iff (!rst_n)
      (ce && !edge_select) |=> (pending_reg == !$past(sync2_reg));
  endproperty
  a_level_follows: assert property (p_level_follows) else $error("Level flag not following pin.");

  property p_no_edge_high;
    @(posedge mclk) disable iff (!rst_n)
      (ce && edge_select && !pending_reg && !fall_seen && !sw_wr) |=> !pending_reg;
  endproperty
  a_no_edge_high: assert property (p_no_edge_high) else $error("Pending set without an edge.");

  c_edge: cover property (@(posedge mclk) disable iff (!rst_n) edge_select && fall_seen);
  c_level: cover property (@(posedge mclk) disable iff (!rst_n) !edge_select && pending_reg);

endmodule : xirq_detect
`default_nettype wire

// ===== verilog/xirq_pkg.sv
// Package for the extra external interrupt block: register map, field layout and vectors.
// Assumes a core on the same clock that reaches the control register by byte or single-bit access.
//
// What this block does
// - Control register sits at address c0, each bit separately addressable.
// - A single-bit set at bit address c2 sets input B enable.
// - Input C priority bit one means high priority level, zero means low.
// - Input C requests service only while its enable bit is one.
// - Input C edge select one: falling edge; zero: low level triggers.
// - Input C edge mode: pending set on edge, cleared on service.
// - Input B priority bit one means high priority level, zero means low.
// - Input B requests service only while its enable bit is one.
// - Input B edge select one: falling edge; zero: low level triggers.
// - Input B edge mode: pending set on detection, cleared on service.
// - Inputs are alternate functions of upper two pins of auxiliary nibble port.
// - Detection, flagging and servicing behave like the classic external interrupts.
// - Input B vectors to 33 and polls at position 6.
// - Input C vectors to 3b and polls at position 7, lowest.
package xirq_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] XIRQ_CTRL_ADDR   = 8'hc0;
  localparam logic [7:0] XIRQ_CTRL_RESET  = 8'h00;
  localparam logic [4:0] XIRQ_BIT_PAGE    = 5'h18;  // Upper five bits of bit addresses c0..c7.

  // ==========================================================================
  // Field layout within one channel nibble, and nibble positions.
  localparam int XIRQ_F_HIGH_PRIO  = 3;
  localparam int XIRQ_F_ENABLE     = 2;
  localparam int XIRQ_F_PENDING    = 1;
  localparam int XIRQ_F_EDGE_SEL   = 0;
  localparam int XIRQ_CHAN_B       = 0;
  localparam int XIRQ_CHAN_C       = 1;
  localparam int XIRQ_PIN_B        = 2;  // Auxiliary port pin carrying input B.
  localparam int XIRQ_PIN_C        = 3;  // Auxiliary port pin carrying input C.

  // ==========================================================================
  // Vectors and polling positions.
  localparam logic [7:0] XIRQ_VECTOR_B = 8'h33;
  localparam logic [7:0] XIRQ_VECTOR_C = 8'h3b;
  localparam logic [2:0] XIRQ_POLL_B   = 3'h6;
  localparam logic [2:0] XIRQ_POLL_C   = 3'h7;

  // One channel nibble, in register bit order.
  typedef struct packed {
    logic high_priority;
    logic enable;
    logic pending;
    logic edge_select;
  } xirq_chan_type;

  // Core access to the special-function space.
  typedef struct packed {
    logic       byte_wr;
    logic       byte_rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_wr;
    logic [7:0] bit_addr;
    logic       bit_val;
  } xirq_sfr_type;

endpackage : xirq_pkg
